// ### verilog/input_qualifier_lpm_wake.sv
// Input qualification filter with low-power entry and wake sequencing
// Notes on behaviour
// - Period field zero samples the pin on every system clock cycle.
// - Nonzero period n samples the pin once every 2n system clock cycles.
// - One period setting serves each group of eight consecutive pins.
// - Per-pin select chooses three or six samples to validate a change.
// - Three-sample window spans two sampling periods.
// - Six-sample window spans five sampling periods.
// - Glitches not stable across the selected samples are rejected.
// - Idle wake resumes within 20 cycles, 1050 with flash asleep.
// - Standby wake resumes within 100 cycles, 1125 with flash asleep.
// - System clock held 16, 32 or 64 cycles by divider select.
// - Standby stops peripheral clocks; phase-locked loop and watchdog run.
// - Standby drops external clock out 32 to 45 cycles after entry.
// - Idle exits on interrupt, watchdog, nonmaskable or reset pin.
// - After standby the waking interrupt is serviced if enabled.
`timescale 1ns/1ps
`default_nettype none

module input_qualifier_lpm_wake #(
    parameter int NUM_GROUPS = 1
) (
    input  wire logic                                        sys_clk,
    input  wire logic                                        rst,
    input  wire logic [NUM_GROUPS*lpm_qual_pkg::GROUP_PINS-1:0] pins_in,
    input  wire logic [NUM_GROUPS*lpm_qual_pkg::PERIOD_W-1:0] qual_period_field,
    input  wire logic [NUM_GROUPS*lpm_qual_pkg::GROUP_PINS-1:0] qual_sample_select,
    input  wire logic [NUM_GROUPS*lpm_qual_pkg::GROUP_PINS-1:0] wake_pin_enable,
    input  wire logic                                        oscillator_clock,
    input  wire logic                                        idle_exec,
    input  wire logic                                        lowpower_mode,
    input  wire logic [1:0]                                  clock_divider_select,
    input  wire logic [lpm_qual_pkg::STBY_QUAL_W-1:0]        standby_qual_count,
    input  wire logic                                        flash_asleep,
    input  wire logic                                        enabled_interrupt,
    input  wire logic                                        watchdog_interrupt,
    input  wire logic                                     external_nonmaskable_int,
    input  wire logic                                     external_reset_pin_n,
    output logic [NUM_GROUPS*lpm_qual_pkg::GROUP_PINS-1:0]   qualified_out,
    output logic                                             core_clock_enable,
    output logic                                             periph_clock_enable,
    output logic                                             pll_watchdog_enable,
    output logic                                             external_clock_out_en,
    output logic                                             in_low_power,
    output logic                                             cpu_resume,
    output logic                                             service_interrupt
);
    import lpm_qual_pkg::*;

    localparam int NP = NUM_GROUPS * GROUP_PINS;

    // Refuse an empty pin array at elaboration
    if (NUM_GROUPS < 1) begin : g_bad_groups
        $error("NUM_GROUPS must be at least one");
    end

    // Complete module state
    typedef struct packed {
        logic [NP-1:0]                      pin_s1;
        logic [NP-1:0]                      pin_s2;
        logic [NP-1:0][SAMPLES_W-1:0]       samples;
        logic [NP-1:0]                      qual;
        logic [NUM_GROUPS-1:0][PCOUNT_W-1:0] pcount;
        logic [4:0]                         src_s1;
        logic [4:0]                         src_s2;
        logic                               osc_prev;
        lp_state_type                       state;
        logic                               mode;
        logic                               by_interrupt;
        logic [6:0]                         entry_cnt;
        logic [2:0]                         osc_cnt;
        logic [6:0]                         wake_osc_cnt;
        logic [10:0]                        resume_cnt;
        logic [10:0]                        resume_limit;
        logic                               core_en;
        logic                               periph_en;
        logic                               ext_en;
        logic                               resume_p;
        logic                               isr_p;
    } state_type;

    state_type state_reg;
    state_type state_next;

    logic [NUM_GROUPS-1:0] group_tick;
    logic [NP-1:0]         qual_next;
    logic [NP-1:0][SAMPLES_W-1:0] samples_next;

    // Per-group sampling tick and per-pin sample history and decision
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
            localparam int GRP = gi / GROUP_PINS;
            logic [PERIOD_W-1:0] prd;
            logic [SAMPLES_W-1:0] hist;
            logic all_hi;
            logic all_lo;
            assign prd = qual_period_field[GRP*PERIOD_W +: PERIOD_W];
            if (gi % GROUP_PINS == 0) begin : g_tick
                // Zero period ticks every cycle, else every 2n cycles
                assign group_tick[GRP] = (prd == '0) ||
                    (state_reg.pcount[GRP] ==
                     {prd, 1'b0} - PCOUNT_W'(1));
            end
            assign hist = {state_reg.samples[gi][SAMPLES_W-2:0],
                           state_reg.pin_s2[gi]};
            assign samples_next[gi] = group_tick[GRP] ? hist
                                      : state_reg.samples[gi];
            // Three samples span two periods, six span five
            always_comb begin
                if (qual_sample_select[gi] == SEL_SIX) begin
                    all_hi = &state_reg.samples[gi];
                    all_lo = ~|state_reg.samples[gi];
                end else begin
                    all_hi = &state_reg.samples[gi][SHORT_SAMPLES-1:0];
                    all_lo = ~|state_reg.samples[gi][SHORT_SAMPLES-1:0];
                end
            end
            // Only unanimous samples move the output; glitches are held off
            assign qual_next[gi] = all_hi ? 1'b1 :
                                   all_lo ? 1'b0 : state_reg.qual[gi];
        end
    endgenerate

    logic                  osc_tick;
    logic                  wake_src;
    logic                  wake_ok;
    logic [6:0]            hold_cyc;
    logic [6:0]            stby_need;

    // Next-state computation
    always_comb begin
        state_next = state_reg;
        state_next.pin_s1 = pins_in;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.samples = samples_next;
        state_next.qual = qual_next;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            state_next.pcount[g] = group_tick[g] ? '0
                : state_reg.pcount[g] + PCOUNT_W'(1);
        end
        state_next.src_s1 = {oscillator_clock, enabled_interrupt,
                             watchdog_interrupt, external_nonmaskable_int,
                             ~external_reset_pin_n};
        state_next.src_s2 = state_reg.src_s1;
        state_next.osc_prev = state_reg.src_s2[4];
        osc_tick = state_reg.src_s2[4] & ~state_reg.osc_prev;

        // Any enabled wake source; qualified wake pins are active low
        wake_src = |state_reg.src_s2[3:0] |
                   |(wake_pin_enable & ~state_reg.qual);
        // Wake is blocked until enough oscillator ticks since entry
        wake_ok = wake_src && (state_reg.osc_cnt >= WAKE_BLOCK_OSC);

        case (clock_divider_select)
            DIV_SEL_HALF: hold_cyc = HOLD_MID_CYC;
            DIV_SEL_FULL: hold_cyc = HOLD_LONG_CYC;
            default:      hold_cyc = HOLD_SHORT_CYC;
        endcase
        stby_need = STBY_QUAL_BASE + 7'(standby_qual_count);

        state_next.resume_p = 1'b0;
        state_next.isr_p = 1'b0;

        // Entry and tick counters saturate
        if (state_reg.state != LP_RUN) begin
            if (state_reg.entry_cnt != HOLD_LONG_CYC) begin
                state_next.entry_cnt = state_reg.entry_cnt + 7'h01;
            end
            if (osc_tick && state_reg.osc_cnt != WAKE_BLOCK_OSC) begin
                state_next.osc_cnt = state_reg.osc_cnt + 3'h1;
            end
        end

        case (state_reg.state)
            LP_RUN: begin
                if (idle_exec) begin
                    // Caller keeps the external bus quiet on entry
                    state_next.state = LP_HOLD;
                    state_next.mode = lowpower_mode;
                    state_next.entry_cnt = 7'h01;
                    state_next.osc_cnt = '0;
                    state_next.wake_osc_cnt = '0;
                end
            end
            LP_HOLD: begin
                // Core clock keeps running while the pipeline drains
                if (state_reg.entry_cnt >= hold_cyc) begin
                    state_next.state = (state_reg.mode == MODE_STANDBY)
                                       ? LP_STANDBY : LP_IDLE;
                    state_next.core_en = 1'b0;
                    state_next.periph_en = (state_reg.mode == MODE_IDLE);
                end
            end
            LP_IDLE: begin
                if (wake_ok) begin
                    state_next.state = LP_RESUME;
                    state_next.resume_cnt = 11'h001;
                    state_next.resume_limit = flash_asleep
                        ? RESUME_IDLE_SLOW_CYC : RESUME_IDLE_CYC;
                    state_next.by_interrupt = state_reg.src_s2[3];
                end
            end
            LP_STANDBY: begin
                // Wake must hold for the qualified oscillator tick count
                if (!wake_src) begin
                    state_next.wake_osc_cnt = '0;
                end else if (osc_tick) begin
                    state_next.wake_osc_cnt = state_reg.wake_osc_cnt + 7'h01;
                end
                if (wake_ok && (standby_qual_count == '0 ||
                    state_reg.wake_osc_cnt >= stby_need)) begin
                    state_next.state = LP_RESUME;
                    state_next.resume_cnt = 11'h001;
                    state_next.resume_limit = flash_asleep
                        ? RESUME_STBY_SLOW_CYC : RESUME_STBY_CYC;
                    state_next.by_interrupt = state_reg.src_s2[3];
                end
            end
            LP_RESUME: begin
                state_next.core_en = 1'b1;
                state_next.periph_en = 1'b1;
                state_next.ext_en = 1'b1;
                state_next.resume_cnt = state_reg.resume_cnt + 11'h001;
                if (state_reg.resume_cnt >= state_reg.resume_limit) begin
                    state_next.state = LP_RUN;
                    state_next.resume_p = 1'b1;
                    state_next.isr_p = state_reg.by_interrupt;
                end
            end
            default: begin
                state_next.state = LP_RUN;
            end
        endcase

        // External clock out stops at a fixed count into standby entry
        if ((state_reg.state == LP_HOLD || state_reg.state == LP_STANDBY)
            && state_reg.mode == MODE_STANDBY
            && state_reg.entry_cnt >= EXT_CLK_LOW_CYC - 7'h01) begin
            state_next.ext_en = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.state <= LP_RUN;
            state_reg.qual <= '1;
            state_reg.samples <= '1;
            state_reg.core_en <= 1'b1;
            state_reg.periph_en <= 1'b1;
            state_reg.ext_en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from the state register; the PLL and watchdog enable is tied high
    assign qualified_out = state_reg.qual;
    assign core_clock_enable = state_reg.core_en;
    assign periph_clock_enable = state_reg.periph_en;
    assign pll_watchdog_enable = 1'b1;
    assign external_clock_out_en = state_reg.ext_en;
    assign in_low_power = (state_reg.state != LP_RUN);
    assign cpu_resume = state_reg.resume_p;
    assign service_interrupt = state_reg.isr_p;

endmodule

`default_nettype wire

// ### verilog/lpm_qual_pkg.sv
// Constants for the input qualifier and low-power sequencer
package lpm_qual_pkg;

    // Pins sharing one qualification period
    localparam int GROUP_PINS = 8;
    localparam int PERIOD_W   = 8;
    localparam int PCOUNT_W   = 9;
    localparam int SAMPLES_W  = 6;

    // Sample counts and their look-back positions
    localparam int SHORT_SAMPLES = 3;
    localparam int LONG_SAMPLES  = 6;

    // Select encodings
    localparam logic SEL_THREE = 1'b0;
    localparam logic SEL_SIX   = 1'b1;
    localparam logic MODE_IDLE    = 1'b0;
    localparam logic MODE_STANDBY = 1'b1;

    // Pre-stop clock hold per divider select, in system clock cycles
    localparam logic [1:0] DIV_SEL_HALF = 2'h2;
    localparam logic [1:0] DIV_SEL_FULL = 2'h3;
    localparam logic [6:0] HOLD_SHORT_CYC = 7'h10;
    localparam logic [6:0] HOLD_MID_CYC   = 7'h20;
    localparam logic [6:0] HOLD_LONG_CYC  = 7'h40;

    // External clock out drops between 32 and 45 cycles after entry
    localparam logic [6:0] EXT_CLK_LOW_CYC = 7'h20;

    // Wake not honoured before this many oscillator ticks after entry
    localparam logic [2:0] WAKE_BLOCK_OSC = 3'h4;

    // Standby wake qualification base, in oscillator ticks
    localparam logic [6:0] STBY_QUAL_BASE = 7'h02;
    localparam int STBY_QUAL_W = 6;

    // Resume latencies, in system clock cycles
    localparam logic [10:0] RESUME_IDLE_CYC       = 11'h014;
    localparam logic [10:0] RESUME_IDLE_SLOW_CYC  = 11'h41a;
    localparam logic [10:0] RESUME_STBY_CYC       = 11'h064;
    localparam logic [10:0] RESUME_STBY_SLOW_CYC  = 11'h465;

    // Low-power sequencer states
    typedef enum logic [2:0] {
        LP_RUN     = 3'b000,
        LP_HOLD    = 3'b001,
        LP_IDLE    = 3'b010,
        LP_STANDBY = 3'b011,
        LP_RESUME  = 3'b100
    } lp_state_type;

endpackage

// ### tb/lpm_wake_chk.sv
// Port assertions for the input qualifier and low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_chk #(
    parameter int NUM_GROUPS = 1,
    localparam int NP = NUM_GROUPS * lpm_qual_pkg::GROUP_PINS,
    localparam int PW = NUM_GROUPS * lpm_qual_pkg::PERIOD_W
) (
    input wire logic          sys_clk,
    input wire logic          rst,
    input wire logic [NP-1:0] pins_in,
    input wire logic [PW-1:0] qual_period_field,
    input wire logic [NP-1:0] qual_sample_select,
    input wire logic          idle_exec,
    input wire logic          lowpower_mode,
    input wire logic [1:0]    clock_divider_select,
    input wire logic          flash_asleep,
    input wire logic [NP-1:0] qualified_out,
    input wire logic          core_clock_enable,
    input wire logic          periph_clock_enable,
    input wire logic          external_clock_out_en,
    input wire logic          in_low_power,
    input wire logic          cpu_resume,
    input wire logic          service_interrupt
);
    import lpm_qual_pkg::*;
    // Every property samples on the system clock and idles in reset
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // An entry request that the sequencer should take
    logic entry;
    assign entry = idle_exec && !in_low_power;
    hold_short_a: assert property (entry && !clock_divider_select[1]
        |-> ##16 core_clock_enable ##1 !core_clock_enable) else $error("hold not 16");
    hold_mid_a: assert property (entry && clock_divider_select == 2'h2
        |-> ##32 core_clock_enable ##1 !core_clock_enable) else $error("hold not 32");
    xclk_drop_a: assert property (entry && lowpower_mode
        |-> ##31 external_clock_out_en ##[1:14] !external_clock_out_en) else $error("xclk");
    periph_off_a: assert property (!periph_clock_enable
        |-> in_low_power && lowpower_mode) else $error("peripheral clock off outside standby");
    idle_resume_a: assert property ($rose(core_clock_enable) && !lowpower_mode
        && !flash_asleep |-> ##[1:20] cpu_resume) else $error("idle resume late");
    stby_resume_a: assert property ($rose(core_clock_enable) && lowpower_mode
        && !flash_asleep |-> ##[1:100] cpu_resume) else $error("standby resume late");
    resume_exit_a: assert property (cpu_resume
        |-> !in_low_power && $past(in_low_power)) else $error("resume without exit");
    isr_pair_a: assert property (service_interrupt |-> cpu_resume)
        else $error("interrupt service without resume");
    qual_agree_a: assert property ($fell(qualified_out[0])
        && qual_period_field[7:0] == 8'h00 && qual_sample_select[0] == SEL_THREE
        |-> !$past(pins_in[0], 5)) else $error("qualified fall without low samples");
endmodule
bind input_qualifier_lpm_wake lpm_wake_chk #(.NUM_GROUPS(NUM_GROUPS)) i_chk (
    .sys_clk(sys_clk), .rst(rst), .pins_in(pins_in), .idle_exec(idle_exec),
    .qual_period_field(qual_period_field), .flash_asleep(flash_asleep),
    .qual_sample_select(qual_sample_select), .lowpower_mode(lowpower_mode),
    .clock_divider_select(clock_divider_select), .cpu_resume(cpu_resume),
    .qualified_out(qualified_out), .core_clock_enable(core_clock_enable),
    .periph_clock_enable(periph_clock_enable), .in_low_power(in_low_power),
    .external_clock_out_en(external_clock_out_en),
    .service_interrupt(service_interrupt));
`default_nettype wire

// ### tb/wake_source.sv
// Oscillator and external wake source beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module wake_source (
    input  wire logic sys_clk,
    input  wire logic go,
    input  wire logic done,
    output var logic  osc_clk,
    output var logic  wake
);
    // Oscillator runs free, slower than half the system clock
    initial begin
        osc_clk = 1'b0;
        wake = 1'b0;
    end
    always #40 osc_clk = ~osc_clk;
    // Wake waits four ticks after entry, then holds until resume
    always @(posedge sys_clk) begin
        if (go) begin
            repeat (4) @(posedge osc_clk);
            @(posedge sys_clk);
            wake <= 1'b1;
            @(posedge sys_clk iff done);
            wake <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tb/input_qualifier_lpm_wake_tb.sv
// Self-checking bench for the input qualifier and low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module input_qualifier_lpm_wake_tb;
    import lpm_qual_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] pins_in = 8'hff;
    logic [7:0] qual_period_field = 8'h00;
    logic [7:0] qual_sample_select = 8'h00;
    logic       idle_exec = 1'b0;
    logic       lowpower_mode = 1'b0;
    logic [1:0] clock_divider_select = 2'h0;
    logic       flash_asleep = 1'b0;
    logic [1:0] src = 2'h0;
    logic [5:0] stby_q = 6'h00;
    logic       go = 1'b0;
    logic       osc_clk;
    logic       wake;
    logic [7:0] qualified_out;
    logic       core_clock_enable;
    logic       periph_clock_enable;
    logic       pll_watchdog_enable;
    logic       external_clock_out_en;
    logic       in_low_power;
    logic       cpu_resume;
    logic       service_interrupt;
    int         bad_count = 0;
    int         comparisons = 0;
    int         cycles = 0;
    // Wake level steered to the selected source
    wire logic  enabled_interrupt = wake && src == 2'h0;
    wire logic  watchdog_interrupt = wake && src == 2'h1;
    wire logic  external_nonmaskable_int = wake && src == 2'h2;
    wire logic  external_reset_pin_n = !(wake && src == 2'h3);

    always #5 sys_clk = ~sys_clk;

    input_qualifier_lpm_wake i_input_qualifier_lpm_wake (
        .sys_clk(sys_clk), .rst(rst), .pins_in(pins_in),
        .qual_period_field(qual_period_field), .wake_pin_enable(8'h00),
        .qual_sample_select(qual_sample_select), .oscillator_clock(osc_clk),
        .idle_exec(idle_exec), .lowpower_mode(lowpower_mode),
        .clock_divider_select(clock_divider_select), .standby_qual_count(stby_q),
        .flash_asleep(flash_asleep), .enabled_interrupt(enabled_interrupt),
        .watchdog_interrupt(watchdog_interrupt),
        .external_nonmaskable_int(external_nonmaskable_int),
        .external_reset_pin_n(external_reset_pin_n),
        .qualified_out(qualified_out), .core_clock_enable(core_clock_enable),
        .periph_clock_enable(periph_clock_enable),
        .pll_watchdog_enable(pll_watchdog_enable),
        .external_clock_out_en(external_clock_out_en),
        .in_low_power(in_low_power), .cpu_resume(cpu_resume),
        .service_interrupt(service_interrupt));

    wake_source i_wake_source (.sys_clk(sys_clk), .go(go), .done(cpu_resume),
        .osc_clk(osc_clk), .wake(wake));

    // Verdict and end of run
    task automatic end_sim;
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Low pulse on pins 0 and 7; records which outputs ever went low
    task automatic pulse(input logic [7:0] prd, input logic [7:0] sel,
                         input int len, input logic [7:0] exp_seen);
        logic [7:0] seen = 8'h00;
        qual_period_field <= prd;
        qual_sample_select <= sel;
        repeat (40) @(posedge sys_clk);
        pins_in <= 8'h7e;
        for (int i = 0; i < len + 60; i++) begin
            @(posedge sys_clk);
            if (i == len - 1) begin
                pins_in <= 8'hff;
            end
            #1;
            seen = seen | ~qualified_out;
        end
        chk_byte("seen_low", exp_seen, seen);
        chk_byte("settled_high", 8'hff, qualified_out);
    endtask

    // One low-power entry, hold count, wake and resume latency
    task automatic run_lp(input logic mode, input logic [1:0] dsel,
                          input logic [1:0] s, input logic fl);
        int n;
        int lat;
        logic [6:0] h;
        logic [10:0] lim;
        h = dsel == DIV_SEL_FULL ? HOLD_LONG_CYC
          : dsel == DIV_SEL_HALF ? HOLD_MID_CYC : HOLD_SHORT_CYC;
        lim = mode ? (fl ? RESUME_STBY_SLOW_CYC : RESUME_STBY_CYC)
                   : (fl ? RESUME_IDLE_SLOW_CYC : RESUME_IDLE_CYC);
        lowpower_mode <= mode;
        clock_divider_select <= dsel;
        src <= s;
        flash_asleep <= fl;
        idle_exec <= 1'b1;
        go <= 1'b1;
        @(posedge sys_clk);
        idle_exec <= 1'b0;
        go <= 1'b0;
        for (n = 1; n < 100 && core_clock_enable !== 1'b0; n++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_bit("hold_cycles", 1'b1, n == h + 1);
        chk_bit("periph_clock", !mode, periph_clock_enable);
        chk_bit("pll_watchdog", 1'b1, pll_watchdog_enable);
        for (n = 0; n < 300 && core_clock_enable !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        for (lat = 0; lat < 1200 && cpu_resume !== 1'b1; lat++) begin
            @(posedge sys_clk);
            #1;
        end
        chk_bit("resumed", 1'b1, cpu_resume);
        chk_bit("resume_in_time", 1'b1, lat <= lim);
        chk_bit("isr_pulse", s == 2'h0, service_interrupt);
        chk_bit("left_low_power", 1'b0, in_low_power);
        repeat (4) @(posedge sys_clk);
    endtask

    // Cut a hung run short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            chk_bit("timeout", 1'b0, 1'b1);
            end_sim();
        end
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_byte("qual_reset", 8'hff, qualified_out);
        chk_bit("core_clk_reset", 1'b1, core_clock_enable);
        chk_bit("xclk_reset", 1'b1, external_clock_out_en);
        pulse(8'h00, 8'h80, 2, 8'h00);
        pulse(8'h00, 8'h80, 4, 8'h01);
        pulse(8'h00, 8'h80, 7, 8'h81);
        pulse(8'h00, 8'h81, 5, 8'h00);
        pulse(8'h02, 8'h00, 7, 8'h00);
        pulse(8'h02, 8'h00, 13, 8'h81);
        run_lp(MODE_IDLE, 2'h0, 2'h0, 1'b0);
        run_lp(MODE_IDLE, 2'h1, 2'h1, 1'b1);
        run_lp(MODE_IDLE, 2'h2, 2'h2, 1'b0);
        run_lp(MODE_IDLE, 2'h3, 2'h3, 1'b0);
        run_lp(MODE_STANDBY, 2'h2, 2'h0, 1'b0);
        stby_q <= 6'h03;
        run_lp(MODE_STANDBY, 2'h3, 2'h0, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
